// file: isa_capability_pkg.sv
// Constants, field layout, encodings and default extension sets of the capability register
// =============================================================================
// Functional notes
// - Register always readable; unimplemented variant reads zero
// - Width code field is read-only
// - Width codes 1,2,3 give 32,64,128 bits
// - Register is as wide as machine width
// - One extension bit per letter, A..Z
// - I set for full base; E reads ~I
// - Bitmap is write-any/read-legal, some bits writable
// - Reset loads maximal set, I preferred over E
// - Cleared extension behaves as if absent
// - Reserved bitmap positions always read zero
// - S, U, X set when supported
// - B set only if all three groups
// - Enabling dependent without its base clears both
// - Unsupported combinations become some supported combination
// - Write raising alignment on misaligned next dropped
// - Re-enabled extension state may hold anything
// - Unsupported writes never raise an exception
// - Legal readback depends only on write, state
// =============================================================================
package isa_capability_pkg;

  // =========================================================================
  // Field layout
  // =========================================================================
  localparam int EXT_W       = 26;
  localparam int MWC_W       = 2;
  localparam int EXT_A       = 0;
  localparam int EXT_B       = 1;
  localparam int EXT_C       = 2;
  localparam int EXT_D       = 3;
  localparam int EXT_E       = 4;
  localparam int EXT_F       = 5;
  localparam int EXT_H       = 7;
  localparam int EXT_I       = 8;
  localparam int EXT_M       = 12;
  localparam int EXT_Q       = 16;
  localparam int EXT_S       = 18;
  localparam int EXT_U       = 20;
  localparam int EXT_V       = 21;
  localparam int EXT_X       = 23;
  // Next-instruction address bit that must be clear for 32-bit alignment
  localparam int PC_ALIGN_BIT = 1;

  // =========================================================================
  // Encodings and masks
  // =========================================================================
  localparam logic [MWC_W-1:0] MWC_32  = 2'h1;
  localparam logic [MWC_W-1:0] MWC_64  = 2'h2;
  localparam logic [MWC_W-1:0] MWC_128 = 2'h3;
  // Bits 6,9,10,11,14,17,19,22,24,25
  localparam logic [EXT_W-1:0] RESERVED_MASK = 26'h34A4E40;
  // A C D F I M S U
  localparam logic [EXT_W-1:0] SUPPORTED_DEF = 26'h014112D;
  // A C D F M may be switched off by software
  localparam logic [EXT_W-1:0] WRITABLE_DEF  = 26'h000102D;

  // Register width for a width code: two to the power code plus four
  function automatic int mwc_width(input logic [MWC_W-1:0] code);
    mwc_width = 1 << (int'(code) + 4);
  endfunction : mwc_width

endpackage : isa_capability_pkg

// file: isa_write_if.sv
// Carrier between the register core and its write legaliser
`timescale 1ns/10ps
`default_nettype none
interface isa_write_if #(
  parameter int PC_W = 32
);
  logic [25:0]     cur_ext;
  logic [25:0]     wr_ext;
  logic [PC_W-1:0] next_pc;
  logic [25:0]     legal_ext;
  logic            suppress;

  modport core      (output cur_ext, output wr_ext, output next_pc,
                     input legal_ext, input suppress);
  modport legalizer (input cur_ext, input wr_ext, input next_pc,
                     output legal_ext, output suppress);
endinterface : isa_write_if
`default_nettype wire

// file: isa_write_legalizer.sv
// Turns an arbitrary bitmap write into a legal one and checks alignment
`timescale 1ns/10ps
`default_nettype none
module isa_write_legalizer #(
  parameter logic [25:0] SUPPORTED = isa_capability_pkg::SUPPORTED_DEF,
  parameter logic [25:0] WRITABLE  = isa_capability_pkg::WRITABLE_DEF
) (
  isa_write_if.legalizer wr
);
  import isa_capability_pkg::*;

  // =========================================================================
  // Legalisation, purely combinational
  // =========================================================================
  always_comb begin
    logic [EXT_W-1:0] v;
    v = (wr.wr_ext & WRITABLE) | (wr.cur_ext & ~WRITABLE);
    // B can only stay set where the build marks all three groups present
    v = v & SUPPORTED & ~RESERVED_MASK;
    // Dependent extensions fall with their base
    if (!v[EXT_F]) v[EXT_D] = 1'b0;
    if (!v[EXT_D]) v[EXT_Q] = 1'b0;
    if (!v[EXT_U]) v[EXT_S] = 1'b0;
    if (!v[EXT_S]) v[EXT_H] = 1'b0;
    // Reduced base cannot host the hypervisor: group acts as one field
    if (!v[EXT_I]) v[EXT_H] = 1'b0;
    v[EXT_E] = ~v[EXT_I];
    wr.legal_ext = v;
  end

  // Dropping C raises alignment to 32 bits
  assign wr.suppress = wr.cur_ext[EXT_C] & ~wr.legal_ext[EXT_C]
                     & wr.next_pc[PC_ALIGN_BIT];

endmodule : isa_write_legalizer
`default_nettype wire

// file: isa_capability_register.sv
// Machine capability register: width code, extension bitmap, write rules
`timescale 1ns/10ps
`default_nettype none
module isa_capability_register #(
  parameter logic [1:0]  MWC         = isa_capability_pkg::MWC_32,
  parameter int          MACHINE_REGISTER_WIDTH       = isa_capability_pkg::mwc_width(MWC),
  parameter bit          IMPLEMENTED = 1'b1,
  parameter logic [25:0] SUPPORTED   = isa_capability_pkg::SUPPORTED_DEF,
  parameter logic [25:0] WRITABLE    = isa_capability_pkg::WRITABLE_DEF
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_csr_we,
  input  wire logic [MACHINE_REGISTER_WIDTH-1:0] i_csr_wdata,
  input  wire logic [MACHINE_REGISTER_WIDTH-1:0] i_next_pc,
  output var  logic [MACHINE_REGISTER_WIDTH-1:0] o_isa_value,
  output var  logic [25:0]      o_ext_enable,
  output var  logic             o_instruction_alignment_32,
  output var  logic             o_write_dropped
);
  import isa_capability_pkg::*;

  // =========================================================================
  // Derived constants
  // =========================================================================
  // Reset set: everything supported; E only when I is absent
  localparam logic [EXT_W-1:0] RESET_EXT_RAW =
    SUPPORTED & ~RESERVED_MASK & ~(26'h0000001 << EXT_E);
  localparam logic [EXT_W-1:0] RESET_EXT =
    RESET_EXT_RAW | ((SUPPORTED[EXT_I] ? 26'h0000000 : 26'h0000001) << EXT_E);
  localparam int MID_W = MACHINE_REGISTER_WIDTH - MWC_W - EXT_W;

  // =========================================================================
  // Register image assembly
  // =========================================================================
  // Code on top, bitmap at the bottom, zeros between
  function automatic logic [MACHINE_REGISTER_WIDTH-1:0] assemble(input logic [EXT_W-1:0] ext);
    logic [MACHINE_REGISTER_WIDTH-1:0] img;
    img = '0;
    if (IMPLEMENTED) begin
      img[MACHINE_REGISTER_WIDTH-1 -: MWC_W] = MWC;
      img[EXT_W-1:0]        = ext;
    end
    assemble = img;
  endfunction : assemble

  // =========================================================================
  // State
  // =========================================================================
  logic [EXT_W-1:0] ext_q;
  logic [EXT_W-1:0] ext_d;
  logic [MACHINE_REGISTER_WIDTH-1:0] value_q;
  logic             instruction_alignment_32_q;
  logic             dropped_q;
  logic             dropped_d;
  logic             take_write;

  // =========================================================================
  // Write legaliser
  // =========================================================================
  isa_write_if #(.PC_W(MACHINE_REGISTER_WIDTH)) wr_if ();

  assign wr_if.cur_ext = ext_q;
  assign wr_if.wr_ext  = i_csr_wdata[EXT_W-1:0];
  assign wr_if.next_pc = i_next_pc;

  isa_write_legalizer #(
    .SUPPORTED (SUPPORTED),
    .WRITABLE  (WRITABLE)
  ) u_legalizer (
    .wr (wr_if.legalizer)
  );

  // =========================================================================
  // Next-state decode
  // =========================================================================
  // A bad value never traps; it is folded into a legal one instead.
  // The whole write is lost if the new alignment would strand the next
  // instruction, so software sees the old value and can retry later.
  always_comb begin
    take_write = IMPLEMENTED && i_csr_we && !wr_if.suppress;
    dropped_d  = IMPLEMENTED && i_csr_we && wr_if.suppress;
    ext_d      = take_write ? wr_if.legal_ext : ext_q;
  end

  // =========================================================================
  // Extension bitmap
  // =========================================================================
  // Reset wins over the clock enable so a frozen core still comes up sane
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_q <= IMPLEMENTED ? RESET_EXT : 26'h0000000;
    end else if (i_ce) begin
      ext_q <= ext_d;
    end
  end

  // =========================================================================
  // Read image
  // =========================================================================
  // Kept as its own flop so the read path has no logic after the register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      value_q <= assemble(IMPLEMENTED ? RESET_EXT : 26'h0000000);
    end else if (i_ce) begin
      value_q <= assemble(ext_d);
    end
  end

  // =========================================================================
  // Alignment state
  // =========================================================================
  // Without C every instruction must sit on a 32-bit boundary
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      instruction_alignment_32_q <= IMPLEMENTED ? ~RESET_EXT[EXT_C] : 1'b1;
    end else if (i_ce) begin
      instruction_alignment_32_q <= ~ext_d[EXT_C];
    end
  end

  // =========================================================================
  // Dropped-write indication
  // =========================================================================
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dropped_q <= 1'b0;
    end else if (i_ce) begin
      dropped_q <= dropped_d;
    end
  end

  // =========================================================================
  // Outputs
  // =========================================================================
  // The rest of the core gates each unit on its enable bit, so a cleared
  // extension decodes as absent even in machine mode. Any state owned by
  // the unit is left alone and comes back undefined when re-enabled.
  assign o_isa_value     = value_q;
  assign o_ext_enable    = ext_q;
  assign o_instruction_alignment_32     = instruction_alignment_32_q;
  assign o_write_dropped = dropped_q;

  // =========================================================================
  // Assertions
  // =========================================================================
  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_n);

  property p_width_code;
    IMPLEMENTED |-> (o_isa_value[MACHINE_REGISTER_WIDTH-1 -: MWC_W] == MWC) &&
                    (MACHINE_REGISTER_WIDTH == (32'h1 << (int'(MWC) + 4)));
  endproperty
  a_width_code: assert property (p_width_code)
    else $error("width code field does not match the register width");

  property p_code_read_only;
    (i_ce && i_csr_we) |=> (o_isa_value[MACHINE_REGISTER_WIDTH-1 -: MWC_W] ==
                            $past(o_isa_value[MACHINE_REGISTER_WIDTH-1 -: MWC_W]));
  endproperty
  a_code_read_only: assert property (p_code_read_only)
    else $error("width code changed after a write");

  property p_unimplemented_zero;
    !IMPLEMENTED |-> (o_isa_value == '0) && (o_ext_enable == '0);
  endproperty
  a_unimplemented_zero: assert property (p_unimplemented_zero)
    else $error("absent register does not read as zero");

  property p_middle_zero;
    o_isa_value[MACHINE_REGISTER_WIDTH-MWC_W-1 -: MID_W] == '0;
  endproperty
  a_middle_zero: assert property (p_middle_zero)
    else $error("bits between code and bitmap are not zero");

  property p_image_matches;
    o_isa_value[EXT_W-1:0] == (IMPLEMENTED ? o_ext_enable : 26'h0000000);
  endproperty
  a_image_matches: assert property (p_image_matches)
    else $error("read image bitmap differs from enable bits");

  property p_reserved_zero;
    (o_isa_value[EXT_W-1:0] & RESERVED_MASK) == 26'h0000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bitmap position reads as one");

  property p_e_complement;
    IMPLEMENTED |-> (o_ext_enable[EXT_E] != o_ext_enable[EXT_I]);
  endproperty
  a_e_complement: assert property (p_e_complement)
    else $error("E bit is not the complement of I");

  property p_supported_only;
    (o_ext_enable & ~SUPPORTED & ~(26'h0000001 << EXT_E)) == 26'h0000000;
  endproperty
  a_supported_only: assert property (p_supported_only)
    else $error("unsupported extension bit reads as one");

  property p_dependencies;
    (o_ext_enable[EXT_D] |-> o_ext_enable[EXT_F]) and
    (o_ext_enable[EXT_Q] |-> o_ext_enable[EXT_D]) and
    (o_ext_enable[EXT_S] |-> o_ext_enable[EXT_U]) and
    (o_ext_enable[EXT_H] |-> o_ext_enable[EXT_S]);
  endproperty
  a_dependencies: assert property (p_dependencies)
    else $error("extension enabled without the one it depends on");

  property p_fd_write;
    (i_ce && i_rst_n && i_csr_we && !i_csr_wdata[EXT_F] && i_csr_wdata[EXT_D] &&
     !o_write_dropped && IMPLEMENTED && WRITABLE[EXT_F] && !wr_if.suppress)
      |=> !o_ext_enable[EXT_F] && !o_ext_enable[EXT_D];
  endproperty
  a_fd_write: assert property (p_fd_write)
    else $error("F clear with D set did not clear both");

  property p_reset_max;
    $rose(i_rst_n) |-> (o_ext_enable == (IMPLEMENTED ? RESET_EXT : 26'h0000000));
  endproperty
  a_reset_max: assert property (p_reset_max)
    else $error("reset did not load the maximal extension set");

  property p_read_only_bits;
    (i_ce && i_csr_we) |=>
      ((o_ext_enable & ~WRITABLE & ~(26'h0000001 << EXT_E)) ==
       ($past(o_ext_enable) & ~WRITABLE & ~(26'h0000001 << EXT_E)));
  endproperty
  a_read_only_bits: assert property (p_read_only_bits)
    else $error("a fixed extension bit changed on write");

  property p_write_result;
    (i_ce && i_rst_n && take_write) |=> (o_ext_enable == $past(wr_if.legal_ext)) &&
                                        !o_write_dropped;
  endproperty
  a_write_result: assert property (p_write_result)
    else $error("accepted write did not load the legalised value");

  property p_suppress;
    (i_ce && i_rst_n && IMPLEMENTED && i_csr_we && o_ext_enable[EXT_C] &&
     !wr_if.legal_ext[EXT_C] && i_next_pc[PC_ALIGN_BIT])
      |=> o_write_dropped && (o_isa_value == $past(o_isa_value)) ##1
          (!o_write_dropped || $past(!i_ce || i_csr_we));
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("misaligning write was not discarded");

  property p_instruction_alignment;
    o_instruction_alignment_32 == !o_ext_enable[EXT_C];
  endproperty
  a_instruction_alignment: assert property (p_instruction_alignment)
    else $error("alignment flag disagrees with C bit");

  property p_freeze;
    (!i_ce && i_rst_n) |=> $stable(o_isa_value) && $stable(o_ext_enable) &&
              $stable(o_write_dropped);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable was low");

  property p_no_spurious_drop;
    (!i_csr_we && i_ce) |=> !o_write_dropped;
  endproperty
  a_no_spurious_drop: assert property (p_no_spurious_drop)
    else $error("dropped flag without a write");

  // =========================================================================
  // Assertions: reset image, fixed bits and write outcomes
  // =========================================================================
  // A reset edge with a write pending loads the reset set, so every
  // write-driven check below leaves such an edge alone.
  property p_reset_image;
    $rose(i_rst_n) |->
      (o_isa_value == assemble(IMPLEMENTED ? RESET_EXT : 26'h0000000)) &&
      !o_write_dropped &&
      (o_instruction_alignment_32 == (IMPLEMENTED ? ~RESET_EXT[EXT_C] : 1'b1));
  endproperty
  a_reset_image: assert property (p_reset_image)
    else $error("read image after reset is not the full set");

  property p_full_base;
    (IMPLEMENTED && SUPPORTED[EXT_I] && $rose(i_rst_n)) |->
      o_ext_enable[EXT_I] && !o_ext_enable[EXT_E];
  endproperty
  a_full_base: assert property (p_full_base)
    else $error("reset chose the reduced base over the full one");

  // Privilege and custom bits follow the build unless software may write them
  property p_fixed_privilege;
    IMPLEMENTED |->
      (WRITABLE[EXT_U] || WRITABLE[EXT_S] || (o_ext_enable[EXT_S] == SUPPORTED[EXT_S])) &&
      (WRITABLE[EXT_U] || (o_ext_enable[EXT_U] == SUPPORTED[EXT_U])) &&
      (WRITABLE[EXT_X] || (o_ext_enable[EXT_X] == SUPPORTED[EXT_X]));
  endproperty
  a_fixed_privilege: assert property (p_fixed_privilege)
    else $error("privilege or custom bit differs from the build");

  property p_e_read_only;
    (i_ce && i_rst_n && i_csr_we && !WRITABLE[EXT_I]) |=> $stable(o_ext_enable[EXT_E]);
  endproperty
  a_e_read_only: assert property (p_e_read_only)
    else $error("E bit moved on a write that cannot touch I");

  property p_drop_keeps_c;
    o_write_dropped |-> o_ext_enable[EXT_C] && !o_instruction_alignment_32;
  endproperty
  a_drop_keeps_c: assert property (p_drop_keeps_c)
    else $error("dropped flag raised while C is off");

  // Every write made while the clock enable is high either lands legalised or is dropped; there is no third path
  property p_one_outcome;
    (i_ce && i_rst_n && IMPLEMENTED && i_csr_we) |=>
      (o_write_dropped != (o_ext_enable == $past(wr_if.legal_ext)));
  endproperty
  a_one_outcome: assert property (p_one_outcome)
    else $error("write neither landed nor was dropped");

  property p_idle_stable;
    (i_ce && i_rst_n && !i_csr_we) |=> $stable(o_ext_enable) && $stable(o_isa_value) &&
                                       $stable(o_instruction_alignment_32);
  endproperty
  a_idle_stable: assert property (p_idle_stable)
    else $error("register moved without a write");

  property p_aligned_no_drop;
    (i_ce && i_rst_n && i_csr_we && !i_next_pc[PC_ALIGN_BIT]) |=> !o_write_dropped;
  endproperty
  a_aligned_no_drop: assert property (p_aligned_no_drop)
    else $error("write dropped although the next address is aligned");

  property p_c_off_no_drop;
    (i_ce && i_rst_n && i_csr_we && !o_ext_enable[EXT_C]) |=> !o_write_dropped;
  endproperty
  a_c_off_no_drop: assert property (p_c_off_no_drop)
    else $error("write dropped although alignment cannot rise");

endmodule : isa_capability_register
`default_nettype wire

// file: isa_capability_register_bench.sv
// Self-checking bench for the capability register
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module isa_capability_register_bench;
  import isa_capability_pkg::*;

  // ===========================================================================
  // Signals and table of ordinary writes
  // ===========================================================================
  localparam int W       = 32;
  localparam int MAX_CYC = 1000;

  typedef struct packed {
    logic [W-1:0] wdata;
    logic [W-1:0] pc;
    logic [25:0]  ext;
    logic         instruction_alignment;
    logic         drop;
  } row_t;

  // Each row starts from the state that the row above left behind
  localparam row_t ROWS [8] = '{
    '{32'h0000_0008, 32'h0000_0000, 26'h0140100, 1'b1, 1'b0},
    '{32'h03FF_FFFF, 32'h0000_0002, 26'h014112D, 1'b0, 1'b0},
    '{32'h0000_0000, 32'h0000_0002, 26'h014112D, 1'b0, 1'b1},
    '{32'h0000_0000, 32'h0000_0004, 26'h0140100, 1'b1, 1'b0},
    '{32'hFC00_0028, 32'h0000_0002, 26'h0140128, 1'b1, 1'b0},
    '{32'h0000_0024, 32'h0000_0002, 26'h0140124, 1'b0, 1'b0},
    '{32'h0000_1008, 32'h0000_0006, 26'h0140124, 1'b0, 1'b1},
    '{32'h0000_1008, 32'h0000_0008, 26'h0141100, 1'b1, 1'b0}
  };

  logic         i_clk = 1'b0;
  logic         i_rst_n;
  logic         i_ce;
  logic         i_csr_we;
  logic [W-1:0] i_csr_wdata;
  logic [W-1:0] i_next_pc;
  logic [W-1:0] o_isa_value;
  logic [25:0]  o_ext_enable;
  logic         o_instruction_alignment_32;
  logic         o_write_dropped;
  logic [W-1:0] absent_value;
  logic [25:0]  absent_ext;
  logic         absent_instruction_alignment;
  logic         absent_dropped;
  int           num_errors  = 0;
  int           checks_done = 0;
  int           cycles      = 0;

  isa_capability_register #(
    .MWC         (MWC_32),
    .IMPLEMENTED (1'b1),
    .SUPPORTED   (SUPPORTED_DEF),
    .WRITABLE    (WRITABLE_DEF)
  ) isa_capability_register_inst (
    .i_clk           (i_clk),
    .i_rst_n         (i_rst_n),
    .i_ce            (i_ce),
    .i_csr_we        (i_csr_we),
    .i_csr_wdata     (i_csr_wdata),
    .i_next_pc       (i_next_pc),
    .o_isa_value     (o_isa_value),
    .o_ext_enable    (o_ext_enable),
    .o_instruction_alignment_32     (o_instruction_alignment_32),
    .o_write_dropped (o_write_dropped)
  );

  // Build without the register, fed the same writes: must read as zero
  isa_capability_register #(
    .MWC         (MWC_32),
    .IMPLEMENTED (1'b0),
    .SUPPORTED   (SUPPORTED_DEF),
    .WRITABLE    (WRITABLE_DEF)
  ) isa_capability_register_absent_inst (
    .i_clk           (i_clk),
    .i_rst_n         (i_rst_n),
    .i_ce            (i_ce),
    .i_csr_we        (i_csr_we),
    .i_csr_wdata     (i_csr_wdata),
    .i_next_pc       (i_next_pc),
    .o_isa_value     (absent_value),
    .o_ext_enable    (absent_ext),
    .o_instruction_alignment_32     (absent_instruction_alignment),
    .o_write_dropped (absent_dropped)
  );

  always #5 i_clk = ~i_clk;

  // ===========================================================================
  // Shared tasks
  // ===========================================================================
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Entered just after a rising edge; returns just after the edge that takes the write
  task automatic write(input logic [W-1:0] wdata, input logic [W-1:0] pc);
    i_csr_we    <= 1'b1;
    i_csr_wdata <= wdata;
    i_next_pc   <= pc;
    @(posedge i_clk);
    i_csr_we    <= 1'b0;
  endtask : write

  task automatic check_state(input logic [25:0] ext, input logic instruction_alignment, input logic drop);
    `CHECK("ext_enable", ext, o_ext_enable)
    `CHECK("isa_value", {MWC_32, 4'h0, ext}, o_isa_value)
    `CHECK("reserved", 26'h0000000, o_ext_enable & RESERVED_MASK)
    `CHECK("instruction_alignment_32", instruction_alignment, o_instruction_alignment_32)
    `CHECK("write_dropped", drop, o_write_dropped)
    `CHECK("absent_value", 32'h0000_0000, absent_value)
    `CHECK("absent_ext", 26'h0000000, absent_ext)
    `CHECK("absent_flags", 2'h2, {absent_instruction_alignment, absent_dropped})
  endtask : check_state

  // A hang ends the run through the same report
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      num_errors++;
      results();
    end
  end

  // ===========================================================================
  // Main sequence
  // ===========================================================================
  initial begin
    i_rst_n     = 1'b0;
    i_ce        = 1'b1;
    i_csr_we    = 1'b0;
    i_csr_wdata = 32'h0000_0000;
    i_next_pc   = 32'h0000_0000;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    check_state(26'h014112D, 1'b0, 1'b0);
    `CHECK("isa_width", 32, $bits(isa_capability_register_inst.o_isa_value))
    @(posedge i_clk);
    foreach (ROWS[k]) begin
      write(ROWS[k].wdata, ROWS[k].pc);
      #1;
      check_state(ROWS[k].ext, ROWS[k].instruction_alignment, ROWS[k].drop);
      @(posedge i_clk);
    end
    // Dropped write flags for exactly one cycle and leaves the register alone
    write(32'h0000_0024, 32'h0000_0000);
    @(posedge i_clk);
    write(32'h0000_0000, 32'h0000_0002);
    #1;
    check_state(26'h0140124, 1'b0, 1'b1);
    @(posedge i_clk);
    #1;
    check_state(26'h0140124, 1'b0, 1'b0);
    // A write while the clock enable is low is not taken
    @(posedge i_clk);
    i_ce <= 1'b0;
    write(32'h0000_0000, 32'h0000_0000);
    #1;
    check_state(26'h0140124, 1'b0, 1'b0);
    // Back-to-back writes: the second sees the result of the first
    @(posedge i_clk);
    i_ce        <= 1'b1;
    i_csr_we    <= 1'b1;
    i_csr_wdata <= 32'h03FF_FFFF;
    i_next_pc   <= 32'h0000_0000;
    @(posedge i_clk);
    i_csr_wdata <= 32'h0000_1000;
    @(posedge i_clk);
    i_csr_we    <= 1'b0;
    #1;
    check_state(26'h0141100, 1'b1, 1'b0);
    // Reset in mid-run wins over a low clock enable and restores the full set
    @(posedge i_clk);
    i_ce    <= 1'b0;
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_ce    <= 1'b1;
    #1;
    check_state(26'h014112D, 1'b0, 1'b0);
    `CHECK("e_bit", 1'b0, o_ext_enable[EXT_E])
    `CHECK("readable", 1'b1, o_isa_value != 32'h0000_0000)
    // First edge after release: still the full set, nothing dropped
    @(posedge i_clk);
    #1;
    check_state(26'h014112D, 1'b0, 1'b0);
    results();
  end

endmodule : isa_capability_register_bench
`default_nettype wire
